// ===== fiq_ctrl.sv
// How it works
// - Fast vector read clears edge source zero
// - Forcing enable/disable commands update forcing status
// - Forced source qualified, never normal, not arbitrated
// - Forced level source drives fast request
// - Forced edge source drives fast request
// - Forcing leaves source zero pending untouched
// - Fast vector always reads source vector zero
// - Fast vector read skips clearing while forcing
// - Normal vector read never clears forced sources
// - Source zero ORed with forced sources
// - Protect bit selects protect or normal mode
// - Normal read: resolve, return, record, push, ack
// - Protect read resolves only; write pushes, acks
// - Protect reads leave context and status alone
// - Normal-mode vector write does nothing
// - No pending source returns spurious vector
// - General mask holds both request lines inactive
// - General mask never blocks idle wake-up
// - End-of-interrupt pops stack, restores previous level
// - Trigger type selects edge or level polarity
// - Enable/disable commands set/clear the written mask bits
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fiq_ctrl (
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   // Interrupt source pins, asynchronous
   input  wire logic [31:0] SRC_IN,
   // Request lines to the core, active low
   output logic             FAST_REQ_N,
   output logic             NORMAL_REQ_N,
   // Idle wake-up indication
   output logic             WAKE_UP,
   // AXI4-Lite slave
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [31:0]      sync1;      // Synchroniser first stage
      logic [31:0]      sync2;      // Synchroniser second stage
      logic [31:0]      prev;       // Previous sampled level
      logic [31:0]      edge_pend;  // Latched edge events
      logic [31:0]      enabled;    // mask_reg
      logic [31:0]      forcing;    // forcing_status_reg
      logic [fiq_pkg::NSRC-1:0][6:0]  mode;  // Source mode fields
      logic [fiq_pkg::NSRC-1:0][31:0] vect;  // Source vectors
      logic [31:0]      spurious;   // spurious_vector_reg
      logic             protect;    // protect_enable
      logic             gmask;      // general_mask
      logic [4:0]       cur_irq;    // current_irq_status
      logic [2:0]       cur_lvl;    // Current level
      logic             cur_valid;  // A level is stacked
      logic [3:0]       sp;         // Stack depth
      logic [fiq_pkg::NLVL-1:0][2:0] stk_lvl;  // Saved levels
      logic [fiq_pkg::NLVL-1:0][4:0] stk_irq;  // Saved numbers
      logic [fiq_pkg::NLVL-1:0]      stk_val;  // Saved validity
      logic [4:0]       held_irq;   // Recorded in protect mode
      logic             held_spur;  // Recorded read was spurious
      logic             fast_n;     // Registered fast request
      logic             norm_n;     // Registered normal request
      logic             wake;       // Registered wake-up
      fiq_pkg::fiq_bus_t bus;       // Bus slave state
      logic [31:0]      rdata;      // Read data
      logic [1:0]       resp;       // Response code
   } fiq_st_t;

   fiq_st_t st;       // Current state
   fiq_st_t next_st;  // Next state

   // Combinational helpers
   logic [31:0] lvl_hi;     // Qualified level per source
   logic [31:0] qual;       // Pending and qualified
   logic [31:0] is_edge;    // Source is edge triggered
   logic [31:0] edge_evt;   // Active edge this cycle
   logic [31:0] eligible;   // Enabled, pending, not forced
   logic [4:0]  best_irq;   // Arbitration winner
   logic [2:0]  best_lvl;   // Winner level
   logic        best_ok;    // Winner beats current
   logic [11:0] wa;         // Write address
   logic [11:0] ra;         // Read address
   logic        do_wr;      // Write taken
   logic        do_rd;      // Read taken
   logic [31:0] rd_val;     // Read mux
   logic        rd_err;     // Unmapped read
   logic        wr_err;     // Unmapped write

   // ==========================================================
   // Qualification and arbitration
   // ==========================================================
   always_comb begin
      lvl_hi   = '0;
      is_edge  = '0;
      edge_evt = '0;
      for (int i = 0; i < fiq_pkg::NSRC; i++) begin
         is_edge[i]  = st.mode[i][fiq_pkg::POS_TYPE_LO];
         lvl_hi[i]   = st.mode[i][fiq_pkg::POS_TYPE_HI] ? st.sync2[i] : ~st.sync2[i];
         // Active edge seen
         edge_evt[i] = is_edge[i] & lvl_hi[i] & (st.sync2[i] ^ st.prev[i]);
      end
      qual = (is_edge & st.edge_pend) | (~is_edge & lvl_hi);
      eligible = qual & st.enabled & ~st.forcing;
      eligible[0] = 1'b0;
      best_irq = '0;
      best_lvl = '0;
      best_ok  = 1'b0;
      for (int i = 1; i < fiq_pkg::NSRC; i++) begin
         if (eligible[i] && (!best_ok || st.mode[i][fiq_pkg::POS_PRIO_HI:0] > best_lvl)) begin
            best_ok  = 1'b1;
            best_irq = 5'(i);
            best_lvl = st.mode[i][fiq_pkg::POS_PRIO_HI:0];
         end
      end
      if (st.cur_valid && best_lvl <= st.cur_lvl) begin
         best_ok = 1'b0;
      end
   end

   // ==========================================================
   // Bus decode
   // ==========================================================
   always_comb begin
      wa     = {S_AXI_AWADDR[11:2], 2'b00};
      ra     = {S_AXI_ARADDR[11:2], 2'b00};
      do_wr  = (st.bus == fiq_pkg::BS_IDLE) && S_AXI_AWVALID && S_AXI_WVALID;
      do_rd  = (st.bus == fiq_pkg::BS_IDLE) && S_AXI_ARVALID && !do_wr;
      rd_err = 1'b0;
      wr_err = !(wa <= fiq_pkg::OFF_NORMAL_VEC ||
                 (wa >= fiq_pkg::OFF_ENABLE_CMD && wa <= fiq_pkg::OFF_DEBUG_CTRL) ||
                 wa == fiq_pkg::OFF_FORCE_EN || wa == fiq_pkg::OFF_FORCE_DIS);
      rd_val = '0;
      if (ra < fiq_pkg::OFF_VECT_BASE) begin
         rd_val = {25'h0, st.mode[ra[6:2]]};
      end else if (ra < fiq_pkg::OFF_NORMAL_VEC) begin
         rd_val = st.vect[ra[6:2]];
      end else begin
         case (ra)
            fiq_pkg::OFF_NORMAL_VEC: rd_val = best_ok ? st.vect[best_irq] : st.spurious;
            fiq_pkg::OFF_FAST_VEC:   rd_val = st.vect[0];
            fiq_pkg::OFF_CUR_STATUS: rd_val = {27'h0, st.cur_irq};
            fiq_pkg::OFF_PENDING:    rd_val = qual;
            fiq_pkg::OFF_MASK:       rd_val = st.enabled;
            fiq_pkg::OFF_CORE_STAT:  rd_val = {30'h0, ~st.norm_n, ~st.fast_n};
            fiq_pkg::OFF_SPURIOUS:   rd_val = st.spurious;
            fiq_pkg::OFF_DEBUG_CTRL: rd_val = {30'h0, st.gmask, st.protect};
            fiq_pkg::OFF_FORCE_STAT: rd_val = st.forcing;
            default:        rd_err = 1'b1;
         endcase
      end
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_st       = st;
      next_st.sync1 = SRC_IN;
      next_st.sync2 = st.sync1;
      next_st.prev  = st.sync2;

      // Bus channel handshakes
      case (st.bus)
         fiq_pkg::BS_IDLE: begin
            if (do_wr) begin
               next_st.bus  = fiq_pkg::BS_WRSP;
               next_st.resp = wr_err ? fiq_pkg::RESP_SLVERR : fiq_pkg::RESP_OKAY;
            end else if (do_rd) begin
               next_st.bus   = fiq_pkg::BS_RRSP;
               next_st.rdata = rd_err ? fiq_pkg::RST_WORD : rd_val;
               next_st.resp  = rd_err ? fiq_pkg::RESP_SLVERR : fiq_pkg::RESP_OKAY;
            end
         end
         fiq_pkg::BS_WRSP: if (S_AXI_BREADY) next_st.bus = fiq_pkg::BS_IDLE;
         fiq_pkg::BS_RRSP: if (S_AXI_RREADY) next_st.bus = fiq_pkg::BS_IDLE;
         default: next_st.bus = fiq_pkg::BS_IDLE;
      endcase

      // Register writes
      if (do_wr && !wr_err) begin
         if (wa < fiq_pkg::OFF_VECT_BASE) begin
            next_st.mode[wa[6:2]] = S_AXI_WDATA[6:0];
         end else if (wa < fiq_pkg::OFF_NORMAL_VEC) begin
            next_st.vect[wa[6:2]] = S_AXI_WDATA;
         end else begin
            case (wa)
               fiq_pkg::OFF_NORMAL_VEC: begin
                  if (st.protect && !st.held_spur) begin
                     next_st.stk_lvl[st.sp[2:0]] = st.cur_lvl;
                     next_st.stk_irq[st.sp[2:0]] = st.cur_irq;
                     next_st.stk_val[st.sp[2:0]] = st.cur_valid;
                     next_st.sp        = st.sp + 4'h1;
                     next_st.cur_irq   = st.held_irq;
                     next_st.cur_lvl   = st.mode[st.held_irq][fiq_pkg::POS_PRIO_HI:0];
                     next_st.cur_valid = 1'b1;
                     if (is_edge[st.held_irq]) begin
                        next_st.edge_pend[st.held_irq] = 1'b0;
                     end
                  end
               end
               fiq_pkg::OFF_ENABLE_CMD:  next_st.enabled = st.enabled | S_AXI_WDATA;
               fiq_pkg::OFF_DISABLE_CMD: next_st.enabled = st.enabled & ~S_AXI_WDATA;
               fiq_pkg::OFF_CLEAR_CMD:   next_st.edge_pend = next_st.edge_pend & ~S_AXI_WDATA;
               fiq_pkg::OFF_SET_CMD:     next_st.edge_pend = next_st.edge_pend | S_AXI_WDATA;
               fiq_pkg::OFF_EOI_CMD: begin
                  if (st.sp != 4'h0) begin
                     next_st.sp        = st.sp - 4'h1;
                     next_st.cur_lvl   = st.stk_lvl[st.sp[2:0] - 3'h1];
                     next_st.cur_irq   = st.stk_irq[st.sp[2:0] - 3'h1];
                     next_st.cur_valid = st.stk_val[st.sp[2:0] - 3'h1];
                  end else begin
                     next_st.cur_valid = 1'b0;
                  end
               end
               fiq_pkg::OFF_SPURIOUS: next_st.spurious = S_AXI_WDATA;
               fiq_pkg::OFF_DEBUG_CTRL: begin
                  next_st.protect = S_AXI_WDATA[fiq_pkg::POS_PROTECT];
                  next_st.gmask   = S_AXI_WDATA[fiq_pkg::POS_GMASK];
               end
               fiq_pkg::OFF_FORCE_EN:  next_st.forcing = st.forcing | S_AXI_WDATA;
               fiq_pkg::OFF_FORCE_DIS: next_st.forcing = st.forcing & ~S_AXI_WDATA;
               default: ;
            endcase
         end
      end

      // Side effects of vector reads
      if (do_rd && ra == fiq_pkg::OFF_FAST_VEC) begin
         // Auto-clear edge source zero unless forcing used
         if (is_edge[0] && st.forcing[fiq_pkg::NSRC-1:1] == '0) begin
            next_st.edge_pend[0] = 1'b0;
         end
      end
      if (do_rd && ra == fiq_pkg::OFF_NORMAL_VEC) begin
         if (st.protect) begin
            next_st.held_irq  = best_irq;
            next_st.held_spur = !best_ok;
         end else if (best_ok) begin
            next_st.stk_lvl[st.sp[2:0]] = st.cur_lvl;
            next_st.stk_irq[st.sp[2:0]] = st.cur_irq;
            next_st.stk_val[st.sp[2:0]] = st.cur_valid;
            next_st.sp        = st.sp + 4'h1;
            next_st.cur_irq   = best_irq;
            next_st.cur_lvl   = best_lvl;
            next_st.cur_valid = 1'b1;
            if (is_edge[best_irq]) begin
               next_st.edge_pend[best_irq] = 1'b0;
            end
         end
      end
      // New events this cycle survive any clear
      next_st.edge_pend = next_st.edge_pend | edge_evt;

      next_st.fast_n = !(!st.gmask &&
         ((qual[0] && st.enabled[0]) || |(qual & st.enabled & st.forcing & ~32'h1)));
      // Normal line from unforced sources only
      next_st.norm_n = !(!st.gmask && best_ok);
      next_st.wake   = |(qual & st.enabled);
   end

   // Source zero pending untouched by forcing

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st        <= '0;
         st.fast_n <= 1'b1;
         st.norm_n <= 1'b1;
         st.bus    <= fiq_pkg::BS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign FAST_REQ_N    = st.fast_n;
   assign NORMAL_REQ_N  = st.norm_n;
   assign WAKE_UP       = st.wake;
   assign S_AXI_AWREADY = do_wr;
   assign S_AXI_WREADY  = do_wr;
   assign S_AXI_ARREADY = do_rd;
   assign S_AXI_BVALID  = (st.bus == fiq_pkg::BS_WRSP);
   assign S_AXI_BRESP   = st.resp;
   assign S_AXI_RVALID  = (st.bus == fiq_pkg::BS_RRSP);
   assign S_AXI_RRESP   = st.resp;
   assign S_AXI_RDATA   = st.rdata;

endmodule

`default_nettype wire

// ===== fiq_pkg.sv
package fiq_pkg;

   // ==========================================================
   // Geometry
   // ==========================================================
   localparam int NSRC = 32;  // Interrupt sources, source 0 is fast
   localparam int NLVL = 8;   // Priority levels and stack depth

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [11:0] OFF_MODE_BASE   = 12'h000; // source_mode_zero..31
   localparam logic [11:0] OFF_VECT_BASE   = 12'h080; // source_vector_zero..31
   localparam logic [11:0] OFF_NORMAL_VEC  = 12'h100; // normal_vector_reg
   localparam logic [11:0] OFF_FAST_VEC    = 12'h104; // fast_vector_reg
   localparam logic [11:0] OFF_CUR_STATUS  = 12'h108; // current_irq_status
   localparam logic [11:0] OFF_PENDING     = 12'h10c; // pending_reg
   localparam logic [11:0] OFF_MASK        = 12'h110; // mask_reg
   localparam logic [11:0] OFF_CORE_STAT   = 12'h114; // Core request status
   localparam logic [11:0] OFF_ENABLE_CMD  = 12'h120; // enable_cmd_reg
   localparam logic [11:0] OFF_DISABLE_CMD = 12'h124; // disable_cmd_reg
   localparam logic [11:0] OFF_CLEAR_CMD   = 12'h128; // clear_cmd_reg
   localparam logic [11:0] OFF_SET_CMD     = 12'h12c; // Set command
   localparam logic [11:0] OFF_EOI_CMD     = 12'h130; // end_of_irq_cmd
   localparam logic [11:0] OFF_SPURIOUS    = 12'h134; // spurious_vector_reg
   localparam logic [11:0] OFF_DEBUG_CTRL  = 12'h138; // debug_ctrl_reg
   localparam logic [11:0] OFF_FORCE_EN    = 12'h140; // forcing_enable_cmd
   localparam logic [11:0] OFF_FORCE_DIS   = 12'h144; // forcing_disable_cmd
   localparam logic [11:0] OFF_FORCE_STAT  = 12'h148; // forcing_status_reg

   // ==========================================================
   // Field positions and reset values
   // ==========================================================
   localparam int POS_PROTECT      = 0;  // debug_ctrl_reg protect_enable
   localparam int POS_GMASK        = 1;  // debug_ctrl_reg general_mask
   localparam int POS_TYPE_LO      = 5;  // source_trigger_type low bit
   localparam int POS_TYPE_HI      = 6;  // source_trigger_type high bit
   localparam int POS_PRIO_HI      = 2;  // Priority field top bit
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // Bus slave states, one-hot
   typedef enum logic [2:0] {
      BS_IDLE = 3'h1,
      BS_WRSP = 3'h2,
      BS_RRSP = 3'h4
   } fiq_bus_t;

endpackage

// ===== fiq_chk.sv
`timescale 1ns/1ps
`default_nettype none

module fiq_chk (
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   input  wire logic        FAST_REQ_N,
   input  wire logic        NORMAL_REQ_N,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   input  wire logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   input  wire logic        S_AXI_ARREADY,
   input  wire logic [31:0] S_AXI_RDATA,
   input  wire logic [1:0]  S_AXI_RRESP,
   input  wire logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   // ==========================================================
   // Shadow of the debug control bits
   // ==========================================================
   logic [1:0] dcr;  // Protect at bit 0, general mask at bit 1
   logic       dcr_wr;  // Write to debug control taken
   assign dcr_wr = S_AXI_AWVALID && S_AXI_AWREADY && (S_AXI_AWADDR == fiq_pkg::OFF_DEBUG_CTRL);
   // Follow each accepted write of the debug control word
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         dcr <= 2'h0;
      end else if (dcr_wr) begin
         dcr <= S_AXI_WDATA[1:0];
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   sequence wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY;
   endsequence
   sequence rd_at(logic [11:0] a);
      S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == a);
   endsequence
   rst_idle_a: // quiet after reset
      assert property ($rose(RST_B) |-> FAST_REQ_N && NORMAL_REQ_N)
      else $error("request after reset");
   gmask_quiet_a: // both lines off
      assert property (dcr[1] && $past(dcr[1], 2) |-> FAST_REQ_N && NORMAL_REQ_N)
      else $error("request under mask");
   dbg_readback_a: // bit positions
      assert property (rd_at(fiq_pkg::OFF_DEBUG_CTRL) |=> S_AXI_RDATA[1:0] == dcr)
      else $error("debug readback");
   wr_answer_a:
      assert property (wr_taken |=> S_AXI_BVALID)
      else $error("write response late");
   rd_answer_a:
      assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read response late");
   b_hold_a:
      assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   r_hold_a:
      assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read response not held");
   busy_refuse_a:
      assert property (S_AXI_BVALID || S_AXI_RVALID |-> !S_AXI_AWREADY && !S_AXI_ARREADY)
      else $error("taken while busy");
   unmapped_rd_a:
      assert property (rd_at(12'h118) |=> S_AXI_RRESP == fiq_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0)
      else $error("reserved read not refused");
endmodule

bind fiq_ctrl fiq_chk i_fiq_chk (
   .REF_CLK, .RST_B, .FAST_REQ_N, .NORMAL_REQ_N, .S_AXI_AWADDR, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

`default_nettype wire

// ===== fiq_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module fiq_core_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       fast_req_n,
   output logic [7:0]      fast_entries
);
   logic fast_q;  // Fast line one cycle ago
   // Count a fast entry on each falling line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_q       <= 1'b1;
         fast_entries <= 8'h00;
      end else begin
         fast_q <= fast_req_n;
         if (fast_q && !fast_req_n) begin
            fast_entries <= fast_entries + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// ===== tb_fast_irq_forcing_protect_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_fast_irq_forcing_protect_ctrl;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        ref_clk, rst_b, fast_req_n, normal_req_n, wake_up;
   logic [31:0] src_in, wdata, rdata, rd_q;
   logic [11:0] awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr_q;
   logic [7:0]  fast_entries;  // Core model entry count
   int          err_total, checks_done;

   fiq_ctrl i_fiq_ctrl (
      .REF_CLK(ref_clk), .RST_B(rst_b), .SRC_IN(src_in), .FAST_REQ_N(fast_req_n),
      .NORMAL_REQ_N(normal_req_n), .WAKE_UP(wake_up), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   fiq_core_model i_fiq_core_model (
      .clk(ref_clk), .rst_b(rst_b), .fast_req_n(fast_req_n), .fast_entries(fast_entries));

   // ==========================================================
   // Bus and pin helpers
   // ==========================================================
   // Word compare with counting
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Wait for ready or valid, sampled at the falling edge
   task automatic hs(input int sel);
      logic v;
      do begin
         @(negedge ref_clk);
         v = sel == 0 ? awready : sel == 1 ? bvalid : sel == 2 ? arready : rvalid;
         {rd_q, rr_q} = {rdata, rresp};
         @(posedge ref_clk);
      end while (v !== 1'b1);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      hs(0);
      {awvalid, wvalid} <= 2'h0;
      hs(1);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      hs(2);
      arvalid <= 1'b0;
      hs(3);
      rready <= 1'b0;
      chk(rd_q, e);
   endtask
   // Drive one source pin
   task automatic lvl(input int b, input logic v);
      @(posedge ref_clk);
      src_in[b] <= v;
   endtask
   // Settle, then judge a pin: 0 fast, 1 normal, 2 wake
   task automatic see(input int s, input logic e);
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({31'h0, s == 0 ? fast_req_n : s == 1 ? normal_req_n : wake_up}, {31'h0, e});
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_fast;
      rd(fiq_pkg::OFF_DEBUG_CTRL, 32'h0);           // cleared by reset
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h3);
      rd(fiq_pkg::OFF_DEBUG_CTRL, 32'h3);           // mode bits stored
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h0);
      rd(12'h118, 32'h0);
      chk({30'h0, rr_q}, {30'h0, fiq_pkg::RESP_SLVERR});
      wr(fiq_pkg::OFF_MODE_BASE, 32'h60);
      wr(fiq_pkg::OFF_VECT_BASE, 32'h1c00);
      wr(fiq_pkg::OFF_ENABLE_CMD, 32'h1);
      rd(fiq_pkg::OFF_MASK, 32'h1);                 // enabled
      lvl(0, 1'b1);
      see(0, 1'b0);                                 // rising edge taken
      rd(fiq_pkg::OFF_FAST_VEC, 32'h1c00);          // vector zero
      see(0, 1'b1);                                 // edge cleared
      lvl(0, 1'b0);
      wr(fiq_pkg::OFF_MODE_BASE, 32'h40);
      lvl(0, 1'b1);
      rd(fiq_pkg::OFF_FAST_VEC, 32'h1c00);
      see(0, 1'b0);                                 // level kept
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h2);
      see(0, 1'b1);                                 // fast held off
      see(2, 1'b1);                                 // wake still seen
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h0);
      lvl(0, 1'b0);                                 // origin cleared
      see(0, 1'b1);                                 // line released
      chk({24'h0, fast_entries}, 32'h3);
      wr(fiq_pkg::OFF_DISABLE_CMD, 32'h1);
      rd(fiq_pkg::OFF_MASK, 32'h0);                 // disabled
      $display("test fast source done");
   endtask
   task automatic t_force;
      wr(fiq_pkg::OFF_SPURIOUS, 32'h5bad);
      wr(fiq_pkg::OFF_MODE_BASE + 12'h14, 32'h40);
      wr(fiq_pkg::OFF_MODE_BASE + 12'h18, 32'h60);
      wr(fiq_pkg::OFF_MODE_BASE, 32'h60);
      wr(fiq_pkg::OFF_ENABLE_CMD, 32'h61);
      wr(fiq_pkg::OFF_FORCE_EN, 32'h60);
      rd(fiq_pkg::OFF_FORCE_STAT, 32'h60);          // status set
      lvl(5, 1'b1);
      see(0, 1'b0);                                 // level forced
      see(1, 1'b1);                                 // no normal request
      rd(fiq_pkg::OFF_NORMAL_VEC, 32'h5bad);        // spurious vector
      wr(fiq_pkg::OFF_EOI_CMD, 32'h0);              // spurious handler
      rd(fiq_pkg::OFF_PENDING, 32'hffffffbe);       // source zero idle
      lvl(5, 1'b0);
      see(0, 1'b1);
      lvl(6, 1'b1);
      see(0, 1'b0);                                 // edge forced
      rd(fiq_pkg::OFF_NORMAL_VEC, 32'h5bad);        // not arbitrated
      rd(fiq_pkg::OFF_FAST_VEC, 32'h1c00);          // vector zero
      see(0, 1'b0);                                 // reads leave it
      lvl(0, 1'b1);
      see(0, 1'b0);
      rd(fiq_pkg::OFF_FAST_VEC, 32'h1c00);
      rd(fiq_pkg::OFF_PENDING, 32'hffffffdf);       // zero kept pending
      wr(fiq_pkg::OFF_CLEAR_CMD, 32'h40);           // forced edge cleared
      see(0, 1'b0);                                 // zero still drives
      wr(fiq_pkg::OFF_CLEAR_CMD, 32'h1);
      see(0, 1'b1);
      wr(fiq_pkg::OFF_FORCE_DIS, 32'h60);
      rd(fiq_pkg::OFF_FORCE_STAT, 32'h0);           // status cleared
      wr(fiq_pkg::OFF_DISABLE_CMD, 32'h61);
      $display("test forcing done");
   endtask
   task automatic t_protect;
      wr(fiq_pkg::OFF_MODE_BASE + 12'h0c, 32'h43);
      wr(fiq_pkg::OFF_VECT_BASE + 12'h0c, 32'h3300);
      wr(fiq_pkg::OFF_ENABLE_CMD, 32'h8);
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h1);
      lvl(3, 1'b1);
      see(1, 1'b0);
      rd(fiq_pkg::OFF_NORMAL_VEC, 32'h3300);        // vector returned
      rd(fiq_pkg::OFF_NORMAL_VEC, 32'h3300);        // repeated read
      rd(fiq_pkg::OFF_CUR_STATUS, 32'h0);           // status untouched
      wr(fiq_pkg::OFF_NORMAL_VEC, 32'h0);           // write after read
      rd(fiq_pkg::OFF_CUR_STATUS, 32'h3);           // write records
      see(1, 1'b1);                                 // write acknowledges
      wr(fiq_pkg::OFF_EOI_CMD, 32'h0);
      see(1, 1'b0);                                 // level popped
      wr(fiq_pkg::OFF_DEBUG_CTRL, 32'h0);
      rd(fiq_pkg::OFF_NORMAL_VEC, 32'h3300);
      rd(fiq_pkg::OFF_CUR_STATUS, 32'h3);           // read records
      see(1, 1'b1);                                 // read acknowledges
      wr(fiq_pkg::OFF_NORMAL_VEC, 32'h0);
      see(1, 1'b1);                                 // write ignored
      lvl(3, 1'b0);
      wr(fiq_pkg::OFF_EOI_CMD, 32'h0);
      $display("test protect done");
   endtask

   // ==========================================================
   // Run control
   // ==========================================================
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Main sequence
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {src_in, wdata, awaddr, araddr} = '0;
      {err_total, checks_done} = '0;
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_fast();
      t_force();
      t_protect();
      close_out();
   end
   // Watchdog well beyond the expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      close_out();
   end
endmodule

`default_nettype wire
